/* File: rmc_pkg.sv */
// Contract
// - Deceleration-range write stores the value for its table entry and commits it to storage.
// - Dwell-range write stores the value for its table entry and commits it to storage.
// - Auxiliary-range write stores the value for its table entry and commits it to storage.
// - Table entry number is the two low hex digits of the command code.
// - All host codes and selectors in range give an all-zero answer word.
// - Any out-of-range host code or selector places its error code in the answer.
// - Unknown monitor code or table entry 32 and above reports code error 1.
// - Parameter number not enabled for reference reports selection error 2.
// - Write value outside its permitted range reports write range error 3.
// - Parameters 116 to 118 route input functions to pins; bus bit then ignored.
// - By default stroke-end and proximity-dog inputs come from the input connector.
// - Host loads selectors then requests; device loads results and raises active together.
// - Results refresh continuously while the monitor request stays asserted.
// - One-station: results freeze at last values when monitoring-active drops.
// - Unsupported code in either selector sets 1 in the answer's lowest digit.
// - Two-station: item one in result words 0 and 1, item two in 5 and 6.
// - Two-station: missing upper half is filled with the sign of the item.
// - Two-station: all four result words freeze when monitoring-active drops.
// - Write-range command applies the value, then raises command-done.
package rmc_pkg;
   // Command code space
   localparam logic [15:0] WR_CODE_LO = 16'h8000;
   localparam logic [15:0] WR_CODE_HI = 16'h911F;
   localparam logic [7:0]  CLS_DECEL  = 8'h8F;
   localparam logic [7:0]  CLS_DWELL  = 8'h90;
   localparam logic [7:0]  CLS_AUX    = 8'h91;
   localparam logic [7:0]  PT_MIN     = 8'h01;
   localparam logic [7:0]  PT_MAX     = 8'h1F;
   localparam int          PT_ENTRIES = 32;
   localparam int          PT_KINDS   = 3;
   localparam int          PT_IDX_W   = 5;
   // Permitted setting limits of table values
   localparam logic [15:0] DECEL_MAX  = 16'h7FFF;
   localparam logic [15:0] DWELL_MAX  = 16'h7FFF;
   localparam logic [15:0] AUX_MAX    = 16'h0003;
   // Answer digit values
   localparam logic [3:0]  ANS_OK     = 4'h0;
   localparam logic [3:0]  ERR_CODE   = 4'h1;
   localparam logic [3:0]  ERR_SEL    = 4'h2;
   localparam logic [3:0]  ERR_RANGE  = 4'h3;
   // Monitor code space: low byte is the item, half bit picks the upper half
   localparam int          MON_ITEMS    = 16;
   localparam int          MON_HALF_BIT = 8;
   localparam logic [6:0]  MON_RSVD_0   = 7'h00;
   localparam logic [MON_ITEMS-1:0] MON_WIDE_MASK = 16'h00F0;
   // Input functions: eight per routing parameter
   localparam int          IN_FN       = 24;
   localparam int          IN_PER_PAR  = 8;
   localparam int          IN_PINS     = 12;
   localparam logic [IN_FN-1:0] IN_ASSIGN_DEFAULT = 24'h00_0070; // Stroke ends and proximity dog
   localparam logic [15:0] WORD_ZERO   = 16'h0000;
   localparam logic [15:0] WORD_ONES   = 16'hFFFF;

   typedef enum logic [1:0] {PT_DECEL, PT_DWELL, PT_AUX} rmc_pt_kind_e;

   // Write to the point table store and its non-volatile commit
   typedef struct packed {
      rmc_pt_kind_e          kind;
      logic [PT_IDX_W-1:0]   entry;
      logic [15:0]           value;
   } rmc_nv_wr_s;

   // Write forwarded to the parameter logic outside
   typedef struct packed {
      logic [15:0] code;
      logic [15:0] value;
   } rmc_ext_wr_s;

   // Answer word digits, most significant first
   typedef struct packed {
      logic [3:0] spd;
      logic [3:0] pos;
      logic [3:0] cmd;
      logic [3:0] mon;
   } rmc_answer_s;
endpackage

/* File: rmc_mon_sel.sv */
`timescale 1ns/1ps
module rmc_mon_sel (
   // Selector and mode
   input  wire logic [15:0]                     code,
   input  wire logic                            two_station,
   // Monitor sources
   input  wire logic [rmc_pkg::MON_ITEMS-1:0][31:0] items,
   // Selected halves
   output logic      [15:0]                     lo,
   output logic      [15:0]                     hi,
   output logic                                 err
);
   import rmc_pkg::*;
   logic [7:0]  idx;
   logic [7:0]  sel;
   logic        half;
   logic        wide;
   logic [31:0] item;

   // Decode the code and pick the addressed item
   always_comb begin
      idx  = code[7:0];
      sel  = idx - 8'h01;
      half = code[MON_HALF_BIT];
      item = items[sel[3:0]];
      wide = MON_WIDE_MASK[sel[3:0]];
      err  = (idx < 8'h01) || (idx > 8'(MON_ITEMS)) || (code[15:9] != MON_RSVD_0) ||
             (half && (two_station || !wide));
      lo   = half ? item[31:16] : item[15:0];
      hi   = wide ? item[31:16] : (item[15] ? WORD_ONES : WORD_ZERO);
   end
endmodule // rmc_mon_sel

/* File: rmc_pt_store.sv */
`timescale 1ns/1ps
module rmc_pt_store (
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst,
   // Write from the command logic
   input  wire logic                 wr_go,
   input  wire rmc_pkg::rmc_nv_wr_s  wr,
   output logic                      wr_done,
   // Non-volatile commit port
   output logic                      nv_wr_valid,
   output rmc_pkg::rmc_nv_wr_s       nv_wr,
   input  wire logic                 nv_wr_ack,
   // Readback of the table
   input  wire rmc_pkg::rmc_pt_kind_e rd_kind,
   input  wire logic [4:0]           rd_entry,
   output logic      [15:0]          rd_value
);
   import rmc_pkg::*;
   logic [15:0] tbl_q [PT_KINDS][PT_ENTRIES];

   // Working copy of the table, one flop word per kind and entry
   for (genvar k = 0; k < PT_KINDS; k++) begin : g_kind
      for (genvar e = 0; e < PT_ENTRIES; e++) begin : g_entry
         always_ff @(posedge clk) begin
            if (rst) begin
               tbl_q[k][e] <= WORD_ZERO;
            end else if (wr_go && int'(wr.kind) == k && wr.entry == PT_IDX_W'(e)) begin
               tbl_q[k][e] <= wr.value;
            end
         end
      end
   end

   // Commit request held until storage acknowledges it
   always_ff @(posedge clk) begin
      if (rst) begin
         nv_wr_valid <= 1'b0;
         nv_wr       <= '0;
      end else if (wr_go) begin
         nv_wr_valid <= 1'b1;
         nv_wr       <= wr;
      end else if (nv_wr_ack) begin
         nv_wr_valid <= 1'b0;
      end
   end
   assign wr_done = nv_wr_valid && nv_wr_ack;

   // Registered readback
   always_ff @(posedge clk) begin
      if (rst) begin
         rd_value <= WORD_ZERO;
      end else if (int'(rd_kind) < PT_KINDS) begin
         rd_value <= tbl_q[int'(rd_kind)][rd_entry];
      end
   end

   nv_commit_a: assert property (@(posedge clk) disable iff (rst)
      wr_go |=> nv_wr_valid && nv_wr == $past(wr) ##1 tbl_q[int'(nv_wr.kind)][nv_wr.entry] == nv_wr.value)
      else $error("table write not committed");
endmodule // rmc_pt_store

/* File: rmc_cmd_handler.sv */
`timescale 1ns/1ps
module rmc_cmd_handler (
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst,
   // Words and bits written by the host
   input  wire logic [15:0]          monitor_select_word_a,
   input  wire logic [15:0]          monitor_select_word_b,
   input  wire logic [15:0]          command_code_word,
   input  wire logic [15:0]          write_value_word,
   input  wire logic                 monitor_request_bit,
   input  wire logic                 command_request_bit,
   input  wire logic                 refresh_tick,
   // Configuration
   input  wire logic                 two_station,
   input  wire logic                 cfg_load,
   input  wire logic [15:0]          cfg_param_116,
   input  wire logic [15:0]          cfg_param_117,
   input  wire logic [15:0]          cfg_param_118,
   // Monitor sources and selector checks from positioning logic
   input  wire logic [rmc_pkg::MON_ITEMS-1:0][31:0] mon_items,
   input  wire logic [3:0]           pos_sel_err,
   input  wire logic [3:0]           spd_sel_err,
   // Words and bits read by the host
   output logic      [15:0]          monitor_result_word_0,
   output logic      [15:0]          monitor_result_word_1,
   output logic      [15:0]          monitor_result_word_5,
   output logic      [15:0]          monitor_result_word_6,
   output logic      [15:0]          answer_word,
   output logic                      monitoring_active_bit,
   output logic                      command_done_bit,
   // Non-volatile commit port
   output logic                      nv_wr_valid,
   output rmc_pkg::rmc_nv_wr_s       nv_wr,
   input  wire logic                 nv_wr_ack,
   // Other write codes go to the parameter logic
   output logic                      ext_wr_valid,
   output rmc_pkg::rmc_ext_wr_s      ext_wr,
   input  wire logic                 ext_wr_done,
   input  wire logic [3:0]           ext_wr_err,
   // Table readback
   input  wire rmc_pkg::rmc_pt_kind_e pt_rd_kind,
   input  wire logic [4:0]           pt_rd_entry,
   output logic      [15:0]          pt_rd_value,
   // Input function routing
   input  wire logic [rmc_pkg::IN_PINS-1:0] input_connector_a,
   input  wire logic [rmc_pkg::IN_PINS-1:0] input_connector_b,
   input  wire logic [rmc_pkg::IN_FN-1:0]   fieldbus_inputs,
   output logic      [rmc_pkg::IN_FN-1:0]   input_functions
);
   import rmc_pkg::*;

   typedef enum logic [1:0] {CMD_IDLE, CMD_STORE, CMD_EXT, CMD_DONE} rmc_cmd_e;

   rmc_cmd_e    state_q;
   rmc_answer_s ans_q;
   logic [15:0] a_lo, a_hi, b_lo, b_hi;
   logic        a_err, b_err;
   logic        st_go_q;
   logic        st_done;
   rmc_nv_wr_s  st_wr_q;
   rmc_nv_wr_s  dec_wr;
   logic        in_wr, is_pt, entry_ok, over;
   logic [15:0] limit;
   logic        cmd_start;
   logic [IN_FN-1:0] assign_q;
   logic [IN_FN-1:0] pin_meta_q, pin_sync_q;

   // Monitor item decode for both selectors
   rmc_mon_sel u_sel_a (
      .code        (monitor_select_word_a),
      .two_station (two_station),
      .items       (mon_items),
      .lo          (a_lo),
      .hi          (a_hi),
      .err         (a_err)
   );
   rmc_mon_sel u_sel_b (
      .code        (monitor_select_word_b),
      .two_station (two_station),
      .items       (mon_items),
      .lo          (b_lo),
      .hi          (b_hi),
      .err         (b_err)
   );

   // Monitoring-active follows the request at each refresh
   always_ff @(posedge clk) begin
      if (rst) begin
         monitoring_active_bit <= 1'b0;
      end else if (refresh_tick) begin
         monitoring_active_bit <= monitor_request_bit;
      end
   end

   // Result words load with the active bit, words 5 and 6 in two-station mode only, and hold otherwise
   always_ff @(posedge clk) begin
      if (rst) begin
         monitor_result_word_0 <= WORD_ZERO;
         monitor_result_word_1 <= WORD_ZERO;
         monitor_result_word_5 <= WORD_ZERO;
         monitor_result_word_6 <= WORD_ZERO;
      end else if (refresh_tick && monitor_request_bit) begin
         monitor_result_word_0 <= a_err ? WORD_ZERO : a_lo;
         if (two_station) begin
            monitor_result_word_1 <= a_err ? WORD_ZERO : a_hi;
            monitor_result_word_5 <= b_err ? WORD_ZERO : b_lo;
            monitor_result_word_6 <= b_err ? WORD_ZERO : b_hi;
         end else begin
            monitor_result_word_1 <= b_err ? WORD_ZERO : b_lo;
         end
      end
   end

   // Command decode: range, table entry and value limit
   always_comb begin
      in_wr        = (command_code_word >= WR_CODE_LO) && (command_code_word <= WR_CODE_HI);
      is_pt        = (command_code_word[15:8] == CLS_DECEL) || (command_code_word[15:8] == CLS_DWELL) ||
                     (command_code_word[15:8] == CLS_AUX);
      entry_ok     = (command_code_word[7:0] >= PT_MIN) && (command_code_word[7:0] <= PT_MAX);
      dec_wr.entry = command_code_word[PT_IDX_W-1:0];
      dec_wr.value = write_value_word;
      unique case (command_code_word[15:8])
         CLS_DECEL: begin
            dec_wr.kind = PT_DECEL;
            limit       = DECEL_MAX;
         end
         CLS_DWELL: begin
            dec_wr.kind = PT_DWELL;
            limit       = DWELL_MAX;
         end
         default: begin
            dec_wr.kind = PT_AUX;
            limit       = AUX_MAX;
         end
      endcase
      over      = write_value_word > limit;
      cmd_start = (state_q == CMD_IDLE) && command_request_bit;
   end

   // Command sequence; done stays high until the host drops its request
   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= CMD_IDLE;
      end else begin
         unique case (state_q)
            CMD_IDLE: begin
               if (cmd_start) begin
                  if (!in_wr || (is_pt && (!entry_ok || over))) begin
                     state_q <= CMD_DONE;
                  end else if (is_pt) begin
                     state_q <= CMD_STORE;
                  end else begin
                     state_q <= CMD_EXT;
                  end
               end
            end
            CMD_STORE: begin
               if (st_done) begin
                  state_q <= CMD_DONE;
               end
            end
            CMD_EXT: begin
               if (ext_wr_done) begin
                  state_q <= CMD_DONE;
               end
            end
            CMD_DONE: begin
               if (!command_request_bit) begin
                  state_q <= CMD_IDLE;
               end
            end
         endcase
      end
   end
   assign command_done_bit = (state_q == CMD_DONE);

   // Table write issued once per accepted table-range command
   always_ff @(posedge clk) begin
      if (rst) begin
         st_go_q <= 1'b0;
         st_wr_q <= '0;
      end else begin
         st_go_q <= cmd_start && in_wr && is_pt && entry_ok && !over;
         if (cmd_start) begin
            st_wr_q <= dec_wr;
         end
      end
   end

   // Forwarded write to parameter logic, held until it answers
   always_ff @(posedge clk) begin
      if (rst) begin
         ext_wr_valid <= 1'b0;
         ext_wr       <= '0;
      end else if (cmd_start && in_wr && !is_pt) begin
         ext_wr_valid <= 1'b1;
         ext_wr.code  <= command_code_word;
         ext_wr.value <= write_value_word;
      end else if (ext_wr_done) begin
         ext_wr_valid <= 1'b0;
      end
   end

   // Command digit of the answer word
   always_ff @(posedge clk) begin
      if (rst) begin
         ans_q.cmd <= ANS_OK;
      end else if (cmd_start) begin
         if (!in_wr || (is_pt && !entry_ok)) begin
            ans_q.cmd <= ERR_CODE;
         end else if (is_pt && over) begin
            ans_q.cmd <= ERR_RANGE;
         end else begin
            ans_q.cmd <= ANS_OK;
         end
      end else if (state_q == CMD_EXT && ext_wr_done) begin
         ans_q.cmd <= ext_wr_err;
      end
   end

   // Monitor digit follows each refresh while monitoring is requested; selector digits every cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         ans_q.mon <= ANS_OK;
         ans_q.pos <= ANS_OK;
         ans_q.spd <= ANS_OK;
      end else begin
         if (refresh_tick && monitor_request_bit) begin
            ans_q.mon <= (a_err || b_err) ? ERR_CODE : ANS_OK;
         end
         ans_q.pos <= pos_sel_err;
         ans_q.spd <= spd_sel_err;
      end
   end
   assign answer_word = ans_q;

   // Point table store with commit port
   rmc_pt_store u_store (
      .clk         (clk),
      .rst         (rst),
      .wr_go       (st_go_q),
      .wr          (st_wr_q),
      .wr_done     (st_done),
      .nv_wr_valid (nv_wr_valid),
      .nv_wr       (nv_wr),
      .nv_wr_ack   (nv_wr_ack),
      .rd_kind     (pt_rd_kind),
      .rd_entry    (pt_rd_entry),
      .rd_value    (pt_rd_value)
   );

   // Routing mask from parameters 116 to 118, default after reset
   always_ff @(posedge clk) begin
      if (rst) begin
         assign_q <= IN_ASSIGN_DEFAULT;
      end else if (cfg_load) begin
         assign_q <= {cfg_param_118[IN_PER_PAR-1:0], cfg_param_117[IN_PER_PAR-1:0],
                      cfg_param_116[IN_PER_PAR-1:0]};
      end
   end

   // Connector pins pass two flops before use
   always_ff @(posedge clk) begin
      if (rst) begin
         pin_meta_q <= '0;
         pin_sync_q <= '0;
      end else begin
         pin_meta_q <= {input_connector_b, input_connector_a};
         pin_sync_q <= pin_meta_q;
      end
   end

   // Pin-assigned functions ignore their bus bit
   always_ff @(posedge clk) begin
      if (rst) begin
         input_functions <= '0;
      end else begin
         input_functions <= (assign_q & pin_sync_q) | (~assign_q & fieldbus_inputs);
      end
   end

   mon_load_a: assert property (@(posedge clk) disable iff (rst)
      refresh_tick && monitor_request_bit && !a_err |=>
      monitoring_active_bit && monitor_result_word_0 == $past(a_lo))
      else $error("monitor load missed");

   mon_drop_a: assert property (@(posedge clk) disable iff (rst)
      refresh_tick && !monitor_request_bit |=> !monitoring_active_bit)
      else $error("monitoring active not cleared");

   mon_hold_a: assert property (@(posedge clk) disable iff (rst)
      !monitoring_active_bit && $past(!monitoring_active_bit) && !$past(rst) |->
      $stable(monitor_result_word_0) && $stable(monitor_result_word_1) &&
      $stable(monitor_result_word_5) && $stable(monitor_result_word_6))
      else $error("results changed while not monitoring");

   mon_err_a: assert property (@(posedge clk) disable iff (rst)
      refresh_tick && monitor_request_bit && (a_err || b_err) |=> answer_word[3:0] == ERR_CODE)
      else $error("monitor code error not reported");

   sign_fill_a: assert property (@(posedge clk) disable iff (rst)
      refresh_tick && monitor_request_bit && two_station && !b_err && b_lo[15] &&
      !MON_WIDE_MASK[monitor_select_word_b[3:0] - 4'h1] |=> monitor_result_word_6 == WORD_ONES)
      else $error("sign fill wrong");

   entry_err_a: assert property (@(posedge clk) disable iff (rst)
      cmd_start && is_pt && command_code_word[7:0] > PT_MAX |=>
      command_done_bit && answer_word[7:4] == ERR_CODE && !st_go_q)
      else $error("bad table entry accepted");

   range_err_a: assert property (@(posedge clk) disable iff (rst)
      cmd_start && in_wr && is_pt && entry_ok && over |=> answer_word[7:4] == ERR_RANGE ##1 !nv_wr_valid)
      else $error("range error not reported");

   entry_map_a: assert property (@(posedge clk) disable iff (rst)
      st_go_q |-> st_wr_q.entry == $past(command_code_word[4:0]) && !command_done_bit)
      else $error("table entry mapping wrong");

   done_after_a: assert property (@(posedge clk) disable iff (rst)
      state_q == CMD_STORE && st_done |=> command_done_bit && answer_word[7:4] == ANS_OK)
      else $error("done not raised after store");

   pin_default_a: assert property (@(posedge clk)
      $past(rst) && !rst && !$past(cfg_load) |-> assign_q == IN_ASSIGN_DEFAULT)
      else $error("routing default lost");
endmodule // rmc_cmd_handler

/* File: rmc_host_model.sv */
`timescale 1ns/1ps
// Host side of the command handshake: loads the words, requests, drops after done
module rmc_host_model (
   // Clock
   input  wire logic        clk,
   // Bench control
   input  wire logic        go,
   input  wire logic [15:0] code,
   input  wire logic [15:0] value,
   // Device status
   input  wire logic        command_done_bit,
   // Host words and bit
   output logic      [15:0] command_code_word,
   output logic      [15:0] write_value_word,
   output logic             command_request_bit
);
   initial begin
      command_code_word   = 16'h0000;
      write_value_word    = 16'h0000;
      command_request_bit = 1'b0;
   end
   // Changes on the falling edge, away from the device's sampling edge
   always @(negedge clk) begin
      if (go && !command_request_bit) begin
         command_code_word   <= code;
         write_value_word    <= value; // Plain binary value
         command_request_bit <= 1'b1;
      end else if (command_request_bit && command_done_bit) begin
         command_request_bit <= 1'b0; // Only once done is seen
         command_code_word   <= ~command_code_word; // Released words stop showing the old value
         write_value_word    <= ~write_value_word;
      end
   end
endmodule // rmc_host_model

/* File: rmc_cmd_handler_tb_top.sv */
`timescale 1ns/1ps
module rmc_cmd_handler_tb_top;
   import rmc_pkg::*;
   // Bench signals
   logic clk, rst, go, refresh_tick, two_station, cfg_load, nv_wr_ack, ext_wr_done;
   logic monitor_request_bit, command_request_bit, monitoring_active_bit, command_done_bit;
   logic nv_wr_valid, ext_wr_valid;
   logic [15:0] sel_a, sel_b, c_code, c_val, code_w, val_w, ans, p116, p117, p118, pt_val;
   logic [15:0] w0, w1, w5, w6;
   logic [3:0] ext_err;
   logic [4:0] pt_entry;
   logic [11:0] pin_a, pin_b;
   logic [23:0] fb, fn;
   logic [MON_ITEMS-1:0][31:0] items;
   rmc_pt_kind_e pt_kind;
   rmc_nv_wr_s nv_wr, nv_seen;
   rmc_ext_wr_s ext_seen;
   int fails, checked, nv_n;

   rmc_cmd_handler u_dut (.clk(clk), .rst(rst), .monitor_select_word_a(sel_a), .monitor_select_word_b(sel_b),
      .command_code_word(code_w), .write_value_word(val_w), .monitor_request_bit(monitor_request_bit),
      .command_request_bit(command_request_bit), .refresh_tick(refresh_tick), .two_station(two_station),
      .cfg_load(cfg_load), .cfg_param_116(p116), .cfg_param_117(p117), .cfg_param_118(p118),
      .mon_items(items), .pos_sel_err(4'h0), .spd_sel_err(4'h0), .monitor_result_word_0(w0),
      .monitor_result_word_1(w1), .monitor_result_word_5(w5), .monitor_result_word_6(w6),
      .answer_word(ans), .monitoring_active_bit(monitoring_active_bit), .command_done_bit(command_done_bit),
      .nv_wr_valid(nv_wr_valid), .nv_wr(nv_wr), .nv_wr_ack(nv_wr_ack), .ext_wr_valid(ext_wr_valid),
      .ext_wr(ext_seen), .ext_wr_done(ext_wr_done), .ext_wr_err(ext_err), .pt_rd_kind(pt_kind),
      .pt_rd_entry(pt_entry), .pt_rd_value(pt_val), .input_connector_a(pin_a), .input_connector_b(pin_b),
      .fieldbus_inputs(fb), .input_functions(fn));
   rmc_host_model u_host (.clk(clk), .go(go), .code(c_code), .value(c_val),
      .command_done_bit(command_done_bit), .command_code_word(code_w), .write_value_word(val_w),
      .command_request_bit(command_request_bit));

   // Clock and the storage and parameter-logic responders
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(negedge clk) nv_wr_ack <= nv_wr_valid;
   always @(negedge clk) ext_wr_done <= ext_wr_valid & ~ext_wr_done;
   always @(posedge clk) begin
      if (nv_wr_valid && nv_wr_ack) begin
         nv_seen <= nv_wr;
         nv_n    <= nv_n + 1;
      end
   end

   task automatic finish_test();
      if (fails == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [79:0] exp, input logic [79:0] got);
      checked++;
      if (got !== exp) begin
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
         fails++;
      end
   endtask

   // One command through the host model, judged on the answer digit
   task automatic cmd(input logic [15:0] c, input logic [15:0] v, input logic [3:0] dig);
      int n;
      n = 0;
      @(negedge clk);
      c_code <= c;
      c_val  <= v;
      go     <= 1'b1;
      @(negedge clk);
      go <= 1'b0;
      while (command_done_bit !== 1'b1 && n < 100) begin
         @(negedge clk);
         n++;
      end
      chk("command done", 80'(1), 80'(command_done_bit));
      chk("answer command digit", 80'(dig), 80'(ans[7:4]));
      while (command_done_bit !== 1'b0 && n < 200) begin
         @(negedge clk);
         n++;
      end
   endtask

   task automatic run_table();
      logic [7:0] cls [3];
      cls = '{CLS_DECEL, CLS_DWELL, CLS_AUX};
      for (int k = 0; k < 3; k++) begin
         cmd({cls[k], 8'h13}, 16'h0003 - 16'(k), 4'h0);
         chk("nv write", 80'({2'(k), 5'd19, 16'h0003 - 16'(k)}), 80'(nv_seen));
         chk("nv commits", 80'(k + 1), 80'(nv_n));
         pt_kind  <= rmc_pt_kind_e'(k);
         pt_entry <= 5'd19;
         repeat (3) @(negedge clk);
         chk("table readback", 80'(16'h0003 - 16'(k)), 80'(pt_val));
      end
   endtask

   task automatic run_errors();
      ext_err <= 4'h2;
      cmd(16'h8000, 16'h0001, 4'h2);
      chk("ext write", 80'({16'h8000, 16'h0001}), 80'(ext_seen));
      ext_err <= 4'h0;
      cmd(16'h8F20, 16'h0001, 4'h1);
      cmd(16'h8F00, 16'h0001, 4'h1);
      cmd(16'h9101, 16'h0004, 4'h3);
      cmd(16'h0001, 16'h0000, 4'h1);
      chk("no commit on error", 80'(3), 80'(nv_n));
   endtask

   task automatic tick();
      @(negedge clk);
      refresh_tick <= 1'b1;
      @(negedge clk);
      refresh_tick <= 1'b0;
      @(negedge clk);
   endtask

   task automatic mon_run(input logic two, input logic [15:0] a, input logic [15:0] b);
      @(negedge clk);
      two_station <= two;
      sel_a       <= a;
      sel_b       <= b;
      @(negedge clk);
      monitor_request_bit <= 1'b1; // Selectors first, then the request
      tick();
   endtask

   task automatic mchk(input logic a, input logic [15:0] e0, e1, e5, e6, input logic [3:0] d);
      chk("monitor state", {11'h0, a, e0, e1, e5, e6, d},
          {11'h0, monitoring_active_bit, w0, w1, w5, w6, ans[3:0]});
   endtask

   task automatic mon_drop();
      @(negedge clk);
      monitor_request_bit <= 1'b0;
      items[4]            <= 32'h8000_0001;
      items[0]            <= 32'h0000_0000;
      tick();
   endtask

   task automatic run_monitor();
      mon_run(1'b0, 16'h0005, 16'h0105);
      mchk(1'b1, 16'h5678, 16'h1234, 16'h0000, 16'h0000, 4'h0);
      items[4] <= 32'h0BCD_0EF1;
      tick();
      mchk(1'b1, 16'h0EF1, 16'h0BCD, 16'h0000, 16'h0000, 4'h0);
      mon_drop();
      mchk(1'b0, 16'h0EF1, 16'h0BCD, 16'h0000, 16'h0000, 4'h0);
      items[0] <= 32'h0000_8123; // Upper half differs from the sign fill
      mon_run(1'b1, 16'h0005, 16'h0001);
      mchk(1'b1, 16'h0001, 16'h8000, 16'h8123, 16'hFFFF, 4'h0);
      mon_drop();
      mchk(1'b0, 16'h0001, 16'h8000, 16'h8123, 16'hFFFF, 4'h0);
      mon_run(1'b0, 16'h0011, 16'h0005);
      mchk(1'b1, 16'h0000, 16'h0001, 16'h8123, 16'hFFFF, 4'h1);
   endtask

   task automatic pins(input logic [23:0] m);
      repeat (5) @(negedge clk);
      chk("input functions", 80'(({pin_b, pin_a} & m) | (fb & ~m)), 80'(fn));
   endtask

   task automatic run_pins();
      pins(24'h00_0070);
      @(negedge clk);
      p116     <= 16'h0001;
      p117     <= 16'h0080;
      cfg_load <= 1'b1;
      @(negedge clk);
      cfg_load <= 1'b0;
      pins(24'h00_8001);
   endtask

   // Time-zero values, reset, then the scenarios
   initial begin
      {rst, go, refresh_tick, two_station, cfg_load, monitor_request_bit} = 6'b10_0000;
      {sel_a, sel_b, c_code, c_val, p116, p117, p118} = '0;
      {ext_err, pt_entry, fails, checked, nv_n} = '0;
      pt_kind  = PT_DECEL;
      items    = '0;
      items[0] = 32'hFFFF_8123;
      items[4] = 32'h1234_5678;
      pin_a    = 12'h0A5;
      pin_b    = 12'h3C0;
      fb       = 24'h5A_F00F;
      repeat (6) @(negedge clk);
      rst <= 1'b0;
      @(negedge clk);
      chk("reset outputs", 80'(0), 80'({monitoring_active_bit, command_done_bit, ans, w0}));
      run_table();
      run_errors();
      run_monitor();
      run_pins();
      finish_test();
   end

   // Watchdog well beyond the expected run
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      finish_test();
   end
endmodule // rmc_cmd_handler_tb_top
